// ### rtl/tiec_top.v
// 16-bit interval timer / external event counter with APB register access
`timescale 1ns/1ps
`include "tiec_map.vh"

module tiec_top (
	input wire pclk, // Peripheral clock, 250 MHz
	input wire presetn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction, high for write
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready, always high
	output wire pslverr, // APB error on unmapped address
	input wire event_in, // External event input pin
	output reg timer_out_zero, // Timer output channel zero
	output reg [2:0] timer_out_channel, // Timer outputs channels one to three
	output reg period_match_irq, // Period match pulse
	output reg [2:0] channel_match_irq, // Channel match pulses
	output reg overflow_irq, // Overflow pulse
	output wire irq // Level interrupt, unmasked status set
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] ctl0_reg;
reg [7:0] ctl1_reg;
reg [7:0] ioc0_reg;
reg [7:0] ioc2_reg;
reg [15:0] period_compare_reg;
reg [15:0] period_compare_buffer;
wire [47:0] channel_compare_reg;
reg [15:0] cnt_reg;
reg [15:0] cnt_next;
reg started_reg;
reg [7:0] div_reg;
reg ovf_flag_reg;
reg [4:0] status_reg;
reg [4:0] mask_reg;
reg pm_hit;
reg ov_hit;
wire [2:0] ch_hit;

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire wr_en;
wire rd_setup;
reg addr_ok;

assign pready = 1'b1;
assign wr_en = psel & penable & pwrite & addr_ok;
assign rd_setup = psel & ~penable & ~pwrite;
// Unmapped addresses answer with an error in the access phase and change nothing
assign pslverr = psel & penable & ~addr_ok;

// Only the twelve word addresses below are backed by registers
always @* begin
	case (paddr)
		`TIEC_OFS_CTL0, `TIEC_OFS_CTL1, `TIEC_OFS_IOC0, `TIEC_OFS_IOC2,
		`TIEC_OFS_PCMP, `TIEC_OFS_CCMP1, `TIEC_OFS_CCMP2, `TIEC_OFS_CCMP3,
		`TIEC_OFS_CNT, `TIEC_OFS_OVF, `TIEC_OFS_STAT, `TIEC_OFS_MASK: addr_ok = 1'b1;
		default: addr_ok = 1'b0;
	endcase
end

// Writes land on the access edge; pready never stalls
wire wr_ctl0 = wr_en & (paddr == `TIEC_OFS_CTL0);
wire wr_ctl1 = wr_en & (paddr == `TIEC_OFS_CTL1);
wire wr_ioc0 = wr_en & (paddr == `TIEC_OFS_IOC0);
wire wr_ioc2 = wr_en & (paddr == `TIEC_OFS_IOC2);
wire wr_pcmp = wr_en & (paddr == `TIEC_OFS_PCMP);
wire wr_ovf = wr_en & (paddr == `TIEC_OFS_OVF);
wire wr_stat = wr_en & (paddr == `TIEC_OFS_STAT);
wire wr_mask = wr_en & (paddr == `TIEC_OFS_MASK);

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctl0_reg <= `TIEC_RST_CTL0;
		ctl1_reg <= `TIEC_RST_CTL1;
		ioc0_reg <= `TIEC_RST_IOC0;
		ioc2_reg <= `TIEC_RST_IOC2;
		period_compare_reg <= `TIEC_RST_CMP;
		mask_reg <= `TIEC_RST_MASK;
	end else begin
		// Bits outside the CTL0, CTL1 and IOC2 write masks are masked off and read back as zero
		if (wr_ctl0) begin
			ctl0_reg <= pwdata[7:0] & `TIEC_WMASK_CTL0;
		end
		if (wr_ctl1) begin
			ctl1_reg <= pwdata[7:0] & `TIEC_WMASK_CTL1;
		end
		if (wr_ioc0) begin
			ioc0_reg <= pwdata[7:0];
		end
		if (wr_ioc2) begin
			ioc2_reg <= pwdata[7:0] & `TIEC_WMASK_IOC2;
		end
		if (wr_pcmp) begin
			period_compare_reg <= pwdata[15:0];
		end
		if (wr_mask) begin
			mask_reg <= pwdata[4:0];
		end
	end
end

wire [23:0] ccmp_ofs = {`TIEC_OFS_CCMP3, `TIEC_OFS_CCMP2, `TIEC_OFS_CCMP1};

genvar k;
generate
	for (k = 0; k < 3; k = k + 1) begin : g_ccmp
		reg [15:0] cmp_q;
		// One flop set per channel, so each slice has a single driver
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cmp_q <= `TIEC_RST_CMP;
			end else if (wr_en && paddr == ccmp_ofs[8*k+7:8*k]) begin
				cmp_q <= pwdata[15:0];
			end
		end
		assign channel_compare_reg[16*k+15:16*k] = cmp_q;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Count clock selection

wire run = ctl0_reg[`TIEC_CTL0_RUN_BIT];
wire [2:0] cks = ctl0_reg[`TIEC_CTL0_CKS_MSB:`TIEC_CTL0_CKS_LSB];
wire [2:0] mode = ctl1_reg[`TIEC_CTL1_MODE_MSB:`TIEC_CTL1_MODE_LSB];
wire evt_mode = (mode == `TIEC_MODE_EVENT);
wire int_mode = (mode == `TIEC_MODE_INTERVAL);
wire active = run & (evt_mode | int_mode);
wire [7:0] div_mask = ~(8'hff << cks);
// Prescaler tick once every 2^cks clocks while running
wire presc_tick = ((div_reg & div_mask) == div_mask);
wire evt_edge;
wire tick;

tiec_sync u_sync (
	.pclk(pclk),
	.presetn(presetn),
	.din(event_in),
	.edge_sel(ioc2_reg[`TIEC_IOC2_EES_MSB:`TIEC_IOC2_EES_LSB]),
	.edge_pulse(evt_edge)
);

// Event mode and interval mode with event clock both count edges
assign tick = (evt_mode | ctl1_reg[`TIEC_CTL1_EVCLK_BIT]) ? evt_edge : presc_tick;

// Divider restarts while stopped so each run begins on a full count clock
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_reg <= 8'h00;
	end else if (!active) begin
		div_reg <= 8'h00;
	end else begin
		div_reg <= div_reg + 8'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Counter

// Leaving idle: event mode at once, interval mode on its first count clock
wire start_now = active & ~started_reg & (tick | evt_mode);

// The match test comes before the wrap test, so a match at all ones raises no overflow
always @* begin
	cnt_next = cnt_reg;
	pm_hit = 1'b0;
	ov_hit = 1'b0;
	if (!active) begin
		cnt_next = `TIEC_CNT_IDLE;
	end else if (!started_reg) begin
		if (start_now) begin
			cnt_next = `TIEC_CNT_ZERO;
		end
	end else if (tick) begin
		if (cnt_reg == period_compare_buffer) begin
			cnt_next = `TIEC_CNT_ZERO;
			pm_hit = 1'b1;
		end else if (cnt_reg == `TIEC_CNT_IDLE) begin
			// A period lowered below the count is only met after this wrap
			cnt_next = `TIEC_CNT_ZERO;
			ov_hit = 1'b1;
		end else begin
			cnt_next = cnt_reg + 16'h0001;
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt_reg <= `TIEC_CNT_IDLE;
		started_reg <= 1'b0;
		period_compare_buffer <= `TIEC_RST_CMP;
	end else begin
		cnt_reg <= cnt_next;
		if (!active) begin
			started_reg <= 1'b0;
		end else if (start_now) begin
			started_reg <= 1'b1;
		end
		// A write always reaches the buffer at once, even while counting
		if (wr_pcmp) begin
			period_compare_buffer <= pwdata[15:0];
		end else if (start_now) begin
			period_compare_buffer <= period_compare_reg;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Channel compare and timer outputs

// Bit zero is the period channel, bits one to three the compare channels
wire [3:0] hit_all = {ch_hit, pm_hit};
// Output zero enable is ignored in event mode, so that pin rests at its idle level
wire [3:0] oe_bits = {ioc0_reg[6], ioc0_reg[4], ioc0_reg[2], ioc0_reg[0] & ~evt_mode};
wire [3:0] ol_bits = {ioc0_reg[7], ioc0_reg[5], ioc0_reg[3], ioc0_reg[1]};
wire [3:0] pin_bits;

genvar i;
generate
	for (i = 0; i < 3; i = i + 1) begin : g_chan
		// A value above the period is reached, and matches, only after the period is lowered below the count
		assign ch_hit[i] = active & tick & started_reg &
			(cnt_next == channel_compare_reg[16*i+15:16*i]);
	end
	for (i = 0; i < 4; i = i + 1) begin : g_out
		reg tff_q;
		reg pin_q;
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tff_q <= 1'b0;
				pin_q <= 1'b0;
			end else begin
				if (!active) begin
					tff_q <= ol_bits[i];
				end else if (hit_all[i]) begin
					tff_q <= ~tff_q;
				end
				pin_q <= oe_bits[i] ? tff_q : ol_bits[i];
			end
		end
		assign pin_bits[i] = pin_q;
	end
endgenerate

always @* begin
	timer_out_zero = pin_bits[0];
	timer_out_channel = pin_bits[3:1];
end

////////////////////////////////////////////////////////////////////////////////
// Events, status and interrupt

// Status bit order: period match, channels one to three, overflow
wire [4:0] events = {ov_hit, ch_hit, pm_hit};

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		status_reg <= `TIEC_RST_STAT;
		ovf_flag_reg <= 1'b0;
		period_match_irq <= 1'b0;
		channel_match_irq <= 3'h0;
		overflow_irq <= 1'b0;
	end else begin
		// A new event wins over a clear in the same cycle
		status_reg <= (status_reg & ~(wr_stat ? pwdata[4:0] : 5'h00)) | events;
		// The overflow flag likewise keeps a set that meets a clear
		if (ov_hit) begin
			ovf_flag_reg <= 1'b1;
		end else if (wr_ovf && pwdata[`TIEC_OVF_FLAG_BIT]) begin
			ovf_flag_reg <= 1'b0;
		end
		period_match_irq <= pm_hit;
		channel_match_irq <= ch_hit;
		overflow_irq <= ov_hit;
	end
end

// Level interrupt: any unmasked sticky status bit
assign irq = |(status_reg & mask_reg);

////////////////////////////////////////////////////////////////////////////////
// Read data, captured in the setup phase

reg [31:0] rd_mux;

always @* begin
	case (paddr)
		`TIEC_OFS_CTL0: rd_mux = {24'h000000, ctl0_reg};
		`TIEC_OFS_CTL1: rd_mux = {24'h000000, ctl1_reg};
		`TIEC_OFS_IOC0: rd_mux = {24'h000000, ioc0_reg};
		`TIEC_OFS_IOC2: rd_mux = {24'h000000, ioc2_reg};
		`TIEC_OFS_PCMP: rd_mux = {16'h0000, period_compare_reg};
		`TIEC_OFS_CCMP1: rd_mux = {16'h0000, channel_compare_reg[15:0]};
		`TIEC_OFS_CCMP2: rd_mux = {16'h0000, channel_compare_reg[31:16]};
		`TIEC_OFS_CCMP3: rd_mux = {16'h0000, channel_compare_reg[47:32]};
		`TIEC_OFS_CNT: rd_mux = {16'h0000, cnt_reg};
		`TIEC_OFS_OVF: rd_mux = {31'h00000000, ovf_flag_reg};
		`TIEC_OFS_STAT: rd_mux = {27'h0000000, status_reg};
		`TIEC_OFS_MASK: rd_mux = {27'h0000000, mask_reg};
		default: rd_mux = 32'h00000000;
	endcase
end

// Loaded in the setup cycle and held until the next read setup
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
	end else if (rd_setup) begin
		prdata <= rd_mux;
	end
end

endmodule // tiec_top

// ### rtl/tiec_map.vh
// Register offsets, field positions, reset values and codes of the timer block
`ifndef TIEC_MAP_VH
`define TIEC_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets on the APB (one aligned 32-bit word each)
`define TIEC_OFS_CTL0 8'h00
`define TIEC_OFS_CTL1 8'h04
`define TIEC_OFS_IOC0 8'h08
`define TIEC_OFS_IOC2 8'h0c
`define TIEC_OFS_PCMP 8'h10
`define TIEC_OFS_CCMP1 8'h14
`define TIEC_OFS_CCMP2 8'h18
`define TIEC_OFS_CCMP3 8'h1c
`define TIEC_OFS_CNT 8'h20
`define TIEC_OFS_OVF 8'h24
`define TIEC_OFS_STAT 8'h28
`define TIEC_OFS_MASK 8'h2c

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TIEC_CTL0_RUN_BIT 7
`define TIEC_CTL0_CKS_MSB 2
`define TIEC_CTL0_CKS_LSB 0
`define TIEC_CTL1_MODE_MSB 2
`define TIEC_CTL1_MODE_LSB 0
`define TIEC_CTL1_EVCLK_BIT 5
`define TIEC_IOC2_EES_MSB 3
`define TIEC_IOC2_EES_LSB 2
`define TIEC_OVF_FLAG_BIT 0
`define TIEC_ST_PM_BIT 0
`define TIEC_ST_CH_LSB 1
`define TIEC_ST_OV_BIT 4

////////////////////////////////////////////////////////////////////////////////
// Reset values and write masks
`define TIEC_RST_CTL0 8'h00
`define TIEC_RST_CTL1 8'h00
`define TIEC_RST_IOC0 8'h00
`define TIEC_RST_IOC2 8'h00
`define TIEC_RST_CMP 16'hffff
`define TIEC_RST_STAT 5'h00
`define TIEC_RST_MASK 5'h00
`define TIEC_WMASK_CTL0 8'h87
`define TIEC_WMASK_CTL1 8'he7
`define TIEC_WMASK_IOC2 8'h0f

////////////////////////////////////////////////////////////////////////////////
// Codes and counter values
`define TIEC_MODE_INTERVAL 3'h0
`define TIEC_MODE_EVENT 3'h1
`define TIEC_CNT_IDLE 16'hffff
`define TIEC_CNT_ZERO 16'h0000
`define TIEC_EDGE_NONE 2'h0
`define TIEC_EDGE_RISE 2'h1
`define TIEC_EDGE_FALL 2'h2
`define TIEC_EDGE_BOTH 2'h3

`endif

// ### rtl/tiec_sync.v
// Event input synchroniser and selectable edge detector
`timescale 1ns/1ps
`include "tiec_map.vh"

module tiec_sync (
	input wire pclk, // Peripheral clock
	input wire presetn, // Asynchronous reset, active low
	input wire din, // Asynchronous event pin
	input wire [1:0] edge_sel, // Valid edge select
	output reg edge_pulse // One-cycle pulse per valid edge
);

reg meta_reg;
reg sync_reg;
reg prev_reg;
wire rise;
wire fall;

assign rise = sync_reg & ~prev_reg;
assign fall = ~sync_reg & prev_reg;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta_reg <= 1'b0;
		sync_reg <= 1'b0;
		prev_reg <= 1'b0;
		edge_pulse <= 1'b0;
	end else begin
		meta_reg <= din;
		sync_reg <= meta_reg;
		prev_reg <= sync_reg;
		case (edge_sel)
			`TIEC_EDGE_RISE: edge_pulse <= rise;
			`TIEC_EDGE_FALL: edge_pulse <= fall;
			`TIEC_EDGE_BOTH: edge_pulse <= rise | fall;
			default: edge_pulse <= 1'b0;
		endcase
	end
end

endmodule // tiec_sync

// ### dv/tiec_props.sv
// Port-level checks of the timer block, bound to its top module
`timescale 1ns/1ps
`include "tiec_map.vh"

module tiec_props (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB address
	input wire [31:0] pwdata, // APB write data
	input wire pslverr, // APB error
	input wire timer_out_zero, // Output zero
	input wire [2:0] timer_out_channel, // Channel outputs
	input wire period_match_irq, // Period match pulse
	input wire [2:0] channel_match_irq, // Channel match pulses
	input wire overflow_irq // Overflow pulse
);
	reg [7:0] ioc0_reg;
	reg [2:0] mode_reg;
	reg run_reg;
	reg [1:0] quiet_reg;
	wire wr = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the control bits; quiet counts cycles since a control write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ioc0_reg <= 8'h00;
			mode_reg <= 3'h0;
			run_reg <= 1'b0;
			quiet_reg <= 2'h0;
		end else begin
			if (wr && paddr == `TIEC_OFS_IOC0)
				ioc0_reg <= pwdata[7:0];
			if (wr && paddr == `TIEC_OFS_CTL1)
				mode_reg <= pwdata[2:0];
			if (wr && paddr == `TIEC_OFS_CTL0)
				run_reg <= pwdata[7];
			if (wr && paddr <= `TIEC_OFS_IOC0)
				quiet_reg <= 2'h0;
			else if (quiet_reg != 2'h3)
				quiet_reg <= quiet_reg + 2'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_no_ovf_match: assert property (period_match_irq |-> !overflow_irq)
		else $error("overflow raised with period match");
	a_zero_toggles: assert property (period_match_irq && run_reg && ioc0_reg[0] &&
		quiet_reg == 2'h3 && mode_reg == `TIEC_MODE_INTERVAL
		|=> timer_out_zero != $past(timer_out_zero)) else $error("output zero not toggled");
	a_chan_toggles: assert property (channel_match_irq[0] && run_reg && ioc0_reg[2] &&
		quiet_reg == 2'h3 |=> timer_out_channel[0] != $past(timer_out_channel[0]))
		else $error("channel output not toggled");
	a_stop_no_pulse: assert property (!run_reg && quiet_reg == 2'h3
		|-> !period_match_irq && channel_match_irq == 3'h0) else $error("pulse while stopped");
	a_stop_out_idle: assert property (!run_reg && quiet_reg == 2'h3
		|-> timer_out_zero == ioc0_reg[1]) else $error("output zero not idle when stopped");
	a_event_out_idle: assert property (mode_reg == `TIEC_MODE_EVENT && quiet_reg == 2'h3
		|-> timer_out_zero == ioc0_reg[1]) else $error("output zero driven in event mode");
	a_ovf_gap: assert property (overflow_irq |=> !overflow_irq [*8])
		else $error("overflow pulses too close");
	a_unmapped_err: assert property (psel && penable && paddr > `TIEC_OFS_MASK |-> pslverr)
		else $error("no error on unmapped address");
endmodule // tiec_props

bind tiec_top tiec_props i_tiec_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.timer_out_zero(timer_out_zero), .timer_out_channel(timer_out_channel),
	.period_match_irq(period_match_irq), .channel_match_irq(channel_match_irq),
	.overflow_irq(overflow_irq));

// ### dv/tiec_event_src.sv
// Event pin source: a burst of pulses on request
`timescale 1ns/1ps

module tiec_event_src #(
	parameter HALF = 3
) (
	input wire pclk, // Clock
	input wire start, // Start a burst
	input wire [7:0] n_pulses, // Pulses in the burst
	output wire event_in // Event pin, low when idle
);
	reg [7:0] left_reg = 8'h00;
	reg [7:0] ph_reg = 8'h00;

	// Low then high per pulse, so a burst has as many rises as falls
	always @(posedge pclk) begin
		if (left_reg == 8'h00) begin
			ph_reg <= 8'h00;
			if (start)
				left_reg <= n_pulses;
		end else if (ph_reg == 2 * HALF - 1) begin
			ph_reg <= 8'h00;
			left_reg <= left_reg - 8'h01;
		end else
			ph_reg <= ph_reg + 8'h01;
	end
	assign event_in = left_reg != 8'h00 && ph_reg >= HALF;
endmodule // tiec_event_src

// ### dv/tiec_bench.sv
// Self-checking bench of the timer block
`timescale 1ns/1ps
`include "tiec_map.vh"

module tiec_bench;
	reg pclk, presetn, psel, penable, pwrite, ev_go, err_s;
	reg [7:0] paddr, ev_n;
	reg [31:0] pwdata, rdat;
	wire [31:0] prdata;
	wire pready, pslverr, event_in, timer_out_zero, period_match_irq, overflow_irq, irq;
	wire [2:0] timer_out_channel, channel_match_irq;
	integer num_errors, checks_done, pm_n, c1_n, c2_n, c3_n, ov_n, i, e, s0, s1, s2, s3, s4;

	tiec_top i_tiec_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(event_in), .timer_out_zero(timer_out_zero),
		.timer_out_channel(timer_out_channel), .period_match_irq(period_match_irq),
		.channel_match_irq(channel_match_irq), .overflow_irq(overflow_irq), .irq(irq));
	tiec_event_src i_tiec_event_src (.pclk(pclk), .start(ev_go), .n_pulses(ev_n),
		.event_in(event_in));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		pm_n <= pm_n + period_match_irq;
		c1_n <= c1_n + channel_match_irq[0];
		c2_n <= c2_n + channel_match_irq[1];
		c3_n <= c3_n + channel_match_irq[2];
		ov_n <= ov_n + overflow_irq;
	end

	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				@(posedge pclk);
			end
			rdat = prdata;
			err_s = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rd(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			check($sformatf("reg %h", a), rdat, exp);
		end
	endtask

	task cyc(input integer n);
		begin
			@(posedge pclk);
			#1;
			s0 = pm_n;
			s1 = c1_n;
			s2 = c2_n;
			s3 = ov_n;
			s4 = c3_n;
			repeat (n) @(posedge pclk);
			#1;
		end
	endtask

	task end_of_test;
		begin
			$display("checks %0d errors %0d", checks_done, num_errors);
			if (num_errors == 0 && checks_done > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	initial begin
		#320000;
		num_errors = num_errors + 1;
		end_of_test;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, ev_go, ev_n, presetn} = 0;
		{num_errors, checks_done, pm_n, c1_n, c2_n, c3_n, ov_n} = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TIEC_OFS_CTL0, 32'h0);
		rd(`TIEC_OFS_PCMP, 32'hffff);
		apb(1'b1, `TIEC_OFS_CNT, 32'h5);
		rd(`TIEC_OFS_CNT, 32'hffff);
		rd(8'h30, 32'h0);
		check("pslverr", err_s, 1'b1);
		$display("test reset done");
		// Interval mode, channel one below and channel two above the period
		apb(1'b1, `TIEC_OFS_PCMP, 32'h3);
		apb(1'b1, `TIEC_OFS_CCMP1, 32'h1);
		apb(1'b1, `TIEC_OFS_CCMP2, 32'h5);
		apb(1'b1, `TIEC_OFS_CCMP3, 32'h2);
		apb(1'b1, `TIEC_OFS_IOC0, 32'h55);
		apb(1'b1, `TIEC_OFS_MASK, 32'h1);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h80);
		cyc(20);
		cyc(40);
		check("period", pm_n - s0, 10);
		check("chan1", c1_n - s1, 10);
		check("chan2", c2_n - s2, 0);
		check("chan3", c3_n - s4, 10);
		check("out2", timer_out_channel[1], 1'b0);
		check("irq", irq, 1'b1);
		apb(1'b1, `TIEC_OFS_PCMP, 32'h7);
		cyc(20);
		cyc(40);
		check("period7", pm_n - s0, 5);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h0);
		rd(`TIEC_OFS_CNT, 32'hffff);
		apb(1'b1, `TIEC_OFS_STAT, 32'h1);
		cyc(1);
		check("irq clr", irq, 1'b0);
		check("outs idle", {timer_out_channel, timer_out_zero}, 4'h0);
		$display("test interval done");
		apb(1'b1, `TIEC_OFS_PCMP, 32'h0);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h80);
		cyc(10);
		cyc(20);
		check("period0", pm_n - s0, 20);
		rd(`TIEC_OFS_CNT, 32'h0);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h0);
		apb(1'b1, `TIEC_OFS_PCMP, 32'hffff);
		cyc(1);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h80);
		cyc(65545);
		check("pmax", pm_n - s0, 1);
		check("ovf", ov_n - s3, 0);
		apb(1'b1, `TIEC_OFS_CTL0, 32'h0);
		$display("test period limits done");
		// Event mode over every edge select code
		apb(1'b1, `TIEC_OFS_IOC0, 32'h2);
		apb(1'b1, `TIEC_OFS_CTL1, 32'h1);
		apb(1'b1, `TIEC_OFS_PCMP, 32'h2);
		for (i = 0; i < 4; i = i + 1) begin
			e = (i == 0) ? 0 : (i == 3) ? 20 : 10;
			apb(1'b1, `TIEC_OFS_IOC2, i << 2);
			apb(1'b1, `TIEC_OFS_CTL0, 32'h80);
			rd(`TIEC_OFS_CNT, 32'h0);
			cyc(1);
			@(posedge pclk);
			ev_n <= 8'h0a;
			ev_go <= 1'b1;
			@(posedge pclk);
			ev_go <= 1'b0;
			repeat (80) @(posedge pclk);
			#1;
			check("evmatch", pm_n - s0, e / 3);
			check("out0", timer_out_zero, 1'b1);
			rd(`TIEC_OFS_CNT, e % 3);
			apb(1'b1, `TIEC_OFS_CTL0, 32'h0);
		end
		$display("test event done");
		end_of_test;
	end
endmodule // tiec_bench
